// ===== rtl/flash_host.sv
// Purpose: SPI master that issues flash commands byte by byte
// Assumes: device answers on its data output pin
// Notes:   write bytes move through a valid/ready user stream, read bytes are valid only
`timescale 1ns/1ps
module flash_host #(
  parameter int SCK_HALF_CYC = flash_host_pkg::SCK_HALF
) (
  input  wire logic                  ref_clk,
  input  wire logic                  rst_n,
  input  wire flash_host_pkg::cmd_t  cmd,
  input  wire logic                  cmd_valid,
  output logic                       cmd_ready,
  output logic                       cmd_error,
  input  wire logic [7:0]            wr_data,
  input  wire logic                  wr_valid,
  output logic                       wr_ready,
  output logic [7:0]                 rd_data,
  output logic                       rd_valid,
  output logic                       busy,
  output flash_host_pkg::link_t      link,
  input  wire logic                  miso
);
  import flash_host_pkg::*;

  typedef enum logic [2:0] {
    ST_IDLE, ST_SHIFT, ST_NEXT, ST_DONE
  } state_t;

  function automatic op_info_t decode(input logic [7:0] op);
    op_info_t i;
    i = '{valid: 1'b1, has_addr: 1'b0, has_dummy: 1'b0, kind: KIND_NONE};
    case (op)
      OP_READ_FAST: begin
        i.has_addr = 1'b1;
        i.has_dummy = 1'b1;
        i.kind = KIND_READ;
      end
      OP_READ_SLOW, OP_PROT_READ: begin
        i.has_addr = 1'b1;
        i.kind = KIND_READ;
      end
      OP_ERASE_4K, OP_ERASE_32K, OP_ERASE_64K,
      OP_PROTECT, OP_UNPROTECT: i.has_addr = 1'b1;
      OP_PROGRAM: begin
        i.has_addr = 1'b1;
        i.kind = KIND_WRITE;
      end
      OP_STAT_WRITE: i.kind = KIND_WRITE;
      OP_STAT_READ, OP_ID_READ: i.kind = KIND_READ;
      OP_CHIP_ERASE1, OP_CHIP_ERASE2, OP_WR_ENABLE, OP_WR_DISABLE,
      OP_POWER_DOWN, OP_RESUME: i.kind = KIND_NONE;
      default: i.valid = 1'b0;
    endcase
    return i;
  endfunction : decode

  state_t      state_reg, state_next;
  op_info_t    info_reg, info_next;
  logic [9:0]  left_reg, left_next;
  logic [2:0]  phase_reg, phase_next;
  logic [2:0]  bit_reg, bit_next;
  logic [7:0]  sh_reg, sh_next;
  logic [7:0]  in_reg, in_next;
  logic [23:0] addr_reg, addr_next;
  logic [7:0]  div_reg, div_next;
  logic        sck_reg, sck_next;
  logic        cs_n_reg, cs_n_next;
  logic        mosi_reg, mosi_next;
  logic        cmd_ready_reg, cmd_ready_next;
  logic        err_reg, err_next;
  logic        wr_ready_reg, wr_ready_next;
  logic [7:0]  rd_data_reg, rd_data_next;
  logic        rd_valid_reg, rd_valid_next;
  logic        miso_s1_reg, miso_s2_reg;
  logic        is_data_reg, is_data_next;
  logic        busy_reg, busy_next;
  logic [9:0]  cnt;

  always_ff @(posedge ref_clk) begin
    miso_s1_reg <= miso;
    miso_s2_reg <= miso_s1_reg;
  end

  always_comb begin
    state_next     = state_reg;
    info_next      = info_reg;
    left_next      = left_reg;
    phase_next     = phase_reg;
    bit_next       = bit_reg;
    sh_next        = sh_reg;
    in_next        = in_reg;
    addr_next      = addr_reg;
    div_next       = div_reg;
    sck_next       = sck_reg;
    cs_n_next      = cs_n_reg;
    mosi_next      = mosi_reg;
    cmd_ready_next = 1'b0;
    err_next       = 1'b0;
    wr_ready_next  = 1'b0;
    rd_data_next   = rd_data_reg;
    rd_valid_next  = 1'b0;
    is_data_next   = is_data_reg;
    cnt            = cmd.count;
    case (state_reg)
      ST_IDLE: begin
        sck_next  = 1'b0; // mode 0 idle level
        cs_n_next = 1'b1;
        if (cmd_valid && !cmd_ready_reg) begin
          info_next = decode(cmd.opcode);
          if (!info_next.valid) begin
            // Never send what the device would only ignore
            cmd_ready_next = 1'b1;
            err_next       = 1'b1;
          end else begin
            if (info_next.kind == KIND_WRITE &&
                cmd.opcode == OP_PROGRAM) begin
              if (cnt == 10'h000) cnt = 10'h001;
              if (cnt > 10'(MAX_PROG)) cnt = 10'(MAX_PROG);
            end else if (cmd.opcode == OP_STAT_WRITE) begin
              cnt = 10'h001;
            end else if (cmd.opcode == OP_ID_READ) begin
              if (cnt == 10'h000) cnt = 10'h001;
              if (cnt > 10'(MAX_ID)) cnt = 10'(MAX_ID);
            end else if (info_next.kind == KIND_READ) begin
              if (cnt == 10'h000) cnt = 10'h001;
            end else begin
              cnt = 10'h000;
            end
            left_next    = cnt;
            addr_next    = cmd.addr & ADDR_MASK;
            cs_n_next    = 1'b0;
            sh_next      = cmd.opcode;
            mosi_next    = cmd.opcode[7];
            bit_next     = 3'h0;
            phase_next   = 3'h0; // 0 op, 1-3 addr, 4 dummy, 5 data
            is_data_next = 1'b0;
            div_next     = 8'h00;
            state_next   = ST_SHIFT;
          end
        end
      end
      ST_SHIFT: begin
        div_next = div_reg + 8'h01;
        if (div_reg == 8'(SCK_HALF_CYC - 1)) begin
          div_next = 8'h00;
          sck_next = !sck_reg;
          if (sck_reg) begin
            // Falling edge: host moves its own data out
            // Sync lag puts the bit held at the rise here;
            // needs SCK_HALF_CYC of 2 or more
            in_next = {in_reg[6:0], miso_s2_reg};
            sh_next = {sh_reg[6:0], 1'b0};
            bit_next = bit_reg + 3'h1;
            if (bit_reg == 3'h7) begin
              state_next = ST_NEXT;
            end else begin
              mosi_next = sh_reg[6];
            end
          end
        end
      end
      ST_NEXT: begin
        if (is_data_reg && info_reg.kind == KIND_READ) begin
          rd_data_next  = in_reg;
          rd_valid_next = 1'b1;
          addr_next = (addr_reg == ADDR_MASK) ? 24'h000000 :
                      addr_reg + 24'h000001;
        end
        if (is_data_reg) left_next = left_reg - 10'h001;
        state_next = ST_SHIFT;
        is_data_next = 1'b0;
        if (phase_reg == 3'h0 && info_reg.has_addr) begin
          phase_next = 3'h1;
          sh_next    = addr_reg[23:16];
        end else if (phase_reg inside {3'h1, 3'h2}) begin
          phase_next = phase_reg + 3'h1;
          sh_next    = (phase_reg == 3'h1) ? addr_reg[15:8]
                                           : addr_reg[7:0];
        end else if (phase_reg == 3'h3 && info_reg.has_dummy) begin
          phase_next = 3'h4;
          sh_next    = 8'h00;
        end else if (info_reg.kind != KIND_NONE &&
                     left_reg != 10'((is_data_reg) ? 1 : 0)) begin
          phase_next = 3'h5;
          is_data_next = 1'b1;
          if (info_reg.kind == KIND_WRITE) begin
            // Stall the link until the user supplies the byte
            wr_ready_next = wr_valid && !wr_ready_reg;
            sh_next       = wr_data;
            if (!(wr_valid && !wr_ready_reg)) begin
              // Byte just sent stays counted while stalled
              state_next   = ST_NEXT;
              is_data_next = 1'b0;
            end
          end else begin
            sh_next = 8'hff;
          end
        end else begin
          state_next = ST_DONE;
        end
        mosi_next = sh_next[7];
        bit_next  = 3'h0;
      end
      ST_DONE: begin
        cs_n_next      = 1'b1;
        cmd_ready_next = 1'b1;
        state_next     = ST_IDLE;
      end
      default: state_next = ST_IDLE;
    endcase
    busy_next = !cs_n_next;
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      state_reg     <= ST_IDLE;
      info_reg      <= '0;
      left_reg      <= 10'h000;
      phase_reg     <= 3'h0;
      bit_reg       <= 3'h0;
      sh_reg        <= 8'h00;
      in_reg        <= 8'h00;
      addr_reg      <= 24'h000000;
      div_reg       <= 8'h00;
      sck_reg       <= 1'b0;
      cs_n_reg      <= 1'b1;
      mosi_reg      <= 1'b0;
      cmd_ready_reg <= 1'b0;
      err_reg       <= 1'b0;
      wr_ready_reg  <= 1'b0;
      rd_data_reg   <= 8'h00;
      rd_valid_reg  <= 1'b0;
      is_data_reg   <= 1'b0;
      busy_reg      <= 1'b0;
    end else begin
      state_reg     <= state_next;
      info_reg      <= info_next;
      left_reg      <= left_next;
      phase_reg     <= phase_next;
      bit_reg       <= bit_next;
      sh_reg        <= sh_next;
      in_reg        <= in_next;
      addr_reg      <= addr_next;
      div_reg       <= div_next;
      sck_reg       <= sck_next;
      cs_n_reg      <= cs_n_next;
      mosi_reg      <= mosi_next;
      cmd_ready_reg <= cmd_ready_next;
      err_reg       <= err_next;
      wr_ready_reg  <= wr_ready_next;
      rd_data_reg   <= rd_data_next;
      rd_valid_reg  <= rd_valid_next;
      is_data_reg   <= is_data_next;
      busy_reg      <= busy_next;
    end
  end

  assign cmd_ready = cmd_ready_reg;
  assign cmd_error = err_reg;
  assign wr_ready  = wr_ready_reg;
  assign rd_data   = rd_data_reg;
  assign rd_valid  = rd_valid_reg;
  assign busy      = busy_reg;
  assign link      = '{sck: sck_reg, cs_n: cs_n_reg, mosi: mosi_reg};

endmodule : flash_host

// ===== shared/flash_host_pkg.sv
// Purpose: constants and types for the serial flash host controller
// Assumes: SPI mode 0 link, host drives the serial clock
// Notes:   command lengths follow the opcode table
// Operation
// - Only SPI modes 0 and 3 used
// - Host asserts select, then sends opcode first
// - All bytes shifted most significant bit first
// - Host ends each operation releasing select
// - Address is three bytes, bit 23 down
// - Fast read has dummy; slow read none
// - Three block erases take three address bytes
// - Program takes address then 1 to 256 bytes
// - Protection readback: address then data out
// - Identification read returns one to four bytes
// - Power-down enter and resume: opcode only
package flash_host_pkg;

  localparam logic [7:0] OP_READ_FAST   = 8'h0b;
  localparam logic [7:0] OP_READ_SLOW   = 8'h03;
  localparam logic [7:0] OP_ERASE_4K    = 8'h20;
  localparam logic [7:0] OP_ERASE_32K   = 8'h52;
  localparam logic [7:0] OP_ERASE_64K   = 8'hd8;
  localparam logic [7:0] OP_CHIP_ERASE1 = 8'h60;
  localparam logic [7:0] OP_CHIP_ERASE2 = 8'hc7;
  localparam logic [7:0] OP_PROGRAM     = 8'h02;
  localparam logic [7:0] OP_WR_ENABLE   = 8'h06;
  localparam logic [7:0] OP_WR_DISABLE  = 8'h04;
  localparam logic [7:0] OP_PROTECT     = 8'h36;
  localparam logic [7:0] OP_UNPROTECT   = 8'h39;
  localparam logic [7:0] OP_PROT_READ   = 8'h3c;
  localparam logic [7:0] OP_STAT_READ   = 8'h05;
  localparam logic [7:0] OP_STAT_WRITE  = 8'h01;
  localparam logic [7:0] OP_ID_READ     = 8'h9f;
  localparam logic [7:0] OP_POWER_DOWN  = 8'hb9;
  localparam logic [7:0] OP_RESUME      = 8'hab;

  localparam int          ADDR_BYTES    = 3;
  localparam logic [23:0] ADDR_MASK     = 24'h3fffff;
  localparam int          MAX_PROG      = 256;
  localparam int          MAX_ID        = 4;
  // Half period of the serial clock in ref_clk cycles
  localparam int          SCK_HALF      = 2;

  typedef struct packed {
    logic [7:0]  opcode;
    logic [23:0] addr;
    logic [9:0]  count;
  } cmd_t;

  typedef struct packed {
    logic       sck;
    logic       cs_n;
    logic       mosi;
  } link_t;

  typedef enum logic [1:0] {
    KIND_NONE,
    KIND_WRITE,
    KIND_READ
  } data_kind_t;

  typedef struct packed {
    logic       valid;
    logic       has_addr;
    logic       has_dummy;
    data_kind_t kind;
  } op_info_t;

endpackage : flash_host_pkg

// ===== verification/flash_host_sva.sv
// Purpose: port assertions for the flash host controller
// Assumes: mode 0 link, sck half period of SCK_HALF_CYC cycles
// Notes:   bound into every flash_host instance
`timescale 1ns/1ps
module flash_host_sva #(
  parameter int SCK_HALF_CYC = 2
) (
  input wire logic                  ref_clk,
  input wire logic                  rst_n,
  input wire logic                  cmd_ready,
  input wire logic                  cmd_error,
  input wire logic                  wr_valid,
  input wire logic                  wr_ready,
  input wire logic                  busy,
  input wire flash_host_pkg::link_t link
);
  import flash_host_pkg::*;
  int hi_reg;
  int hi_next;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // Counts high cycles of sck, cleared while low
  always_comb hi_next = link.sck ? hi_reg + 1 : 0;
  always_ff @(posedge ref_clk) hi_reg <= rst_n ? hi_next : 0;

  idle_clk_low_a: assert property (link.cs_n |-> !link.sck)
    else $error("sck not low while deselected");
  sck_half_a: assert property
    ($fell(link.sck) |-> hi_reg == SCK_HALF_CYC)
    else $error("sck high phase has wrong length");
  mosi_hold_a: assert property
    (!link.cs_n && link.sck |-> $stable(link.mosi))
    else $error("mosi moved while sck high");
  busy_frame_a: assert property (busy == !link.cs_n)
    else $error("busy disagrees with select");
  ready_close_a: assert property
    (cmd_ready && !cmd_error |-> $rose(link.cs_n))
    else $error("command done without closing frame");
  ready_pulse_a: assert property (cmd_ready |=> !cmd_ready)
    else $error("cmd_ready longer than one cycle");
  err_ready_a: assert property (cmd_error |-> cmd_ready)
    else $error("cmd_error without cmd_ready");
  err_no_frame_a: assert property
    (cmd_error |-> link.cs_n && $past(link.cs_n, 2))
    else $error("refused opcode opened a frame");
  wr_take_a: assert property (wr_ready |-> wr_valid && !link.cs_n)
    else $error("write byte taken without request");
endmodule : flash_host_sva

bind flash_host flash_host_sva #(.SCK_HALF_CYC(SCK_HALF_CYC)) i_sva (
  .ref_clk(ref_clk),
  .rst_n(rst_n),
  .cmd_ready(cmd_ready),
  .cmd_error(cmd_error),
  .wr_valid(wr_valid),
  .wr_ready(wr_ready),
  .busy(busy),
  .link(link)
);

// ===== verification/flash_dev_model.sv
// Purpose: behavioural serial flash device for the host bench
// Assumes: mode 0 framing, serial clock made by the host
// Notes:   read data is the byte position within the frame
`timescale 1ns/1ps
module flash_dev_model (
  input  wire flash_host_pkg::link_t link,
  output logic                       miso
);
  import flash_host_pkg::*;
  logic [7:0] got[$];
  logic [7:0] sh = 8'h00;
  logic       q = 1'b0;
  int         n = 0;
  int         pos = 0;
  // Released line floats: inverse so stale data never matches
  assign miso = link.cs_n ? ~q : q;
  always @(negedge link.cs_n) begin
    n = 0;
    pos = 0;
    q = 1'b0;
  end
  always @(posedge link.sck) if (!link.cs_n) begin
    sh = {sh[6:0], link.mosi};
    n++;
    if (n == 8) begin
      got.push_back(sh);
      n = 0;
      pos++;
    end
  end
  always @(negedge link.sck) if (!link.cs_n) q = pos[7 - n];
endmodule : flash_dev_model

// ===== verification/flash_host_tb_top.sv
// Purpose: self-checking bench for the flash host controller
// Assumes: device model returns byte position as read data
// Notes:   header and write bytes checked on the wire
`timescale 1ns/1ps
module flash_host_tb_top;
  import flash_host_pkg::*;
  logic       ref_clk, rst_n, cmd_valid, cmd_ready, cmd_error;
  logic       wr_valid, wr_ready, rd_valid, busy, miso;
  logic       wr_seen = 1'b0;
  logic [7:0] wr_data, rd_data;
  cmd_t       cmd;
  link_t      link;
  int         fails, checks, seed;
  logic [7:0] wq[$], exp_rd[$];
  logic [8:0] exp_tx[$], e;
  logic       exp_err[$];
  localparam logic [7:0] op_list [18] = '{OP_READ_FAST, OP_READ_SLOW,
    OP_ERASE_4K, OP_ERASE_32K, OP_ERASE_64K, OP_CHIP_ERASE1,
    OP_CHIP_ERASE2, OP_PROGRAM, OP_WR_ENABLE, OP_WR_DISABLE, OP_PROTECT,
    OP_UNPROTECT, OP_PROT_READ, OP_STAT_READ, OP_STAT_WRITE, OP_ID_READ,
    OP_POWER_DOWN, OP_RESUME};

  flash_host i_dut (.ref_clk(ref_clk), .rst_n(rst_n), .cmd(cmd),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_error(cmd_error),
    .wr_data(wr_data), .wr_valid(wr_valid), .wr_ready(wr_ready),
    .rd_data(rd_data), .rd_valid(rd_valid), .busy(busy), .link(link),
    .miso(miso));
  flash_dev_model i_dev (.link(link), .miso(miso));

  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  task automatic cmp_byte(string what, logic [7:0] x, logic [7:0] g);
    checks++;
    if (g !== x) begin
      fails++;
      $display("mismatch %s expected %h seen %h", what, x, g);
    end
  endtask : cmp_byte

  task automatic cmp_bit(string what, logic x, logic g);
    checks++;
    if (g !== x) begin
      fails++;
      $display("mismatch %s expected %b seen %b", what, x, g);
    end
  endtask : cmp_bit

  // Flags: known, address, dummy, read data, write data
  function automatic logic [4:0] attr(logic [7:0] op);
    case (op)
      OP_READ_FAST: return 5'h1e;
      OP_READ_SLOW, OP_PROT_READ: return 5'h1a;
      OP_ERASE_4K, OP_ERASE_32K, OP_ERASE_64K: return 5'h18;
      OP_PROTECT, OP_UNPROTECT: return 5'h18;
      OP_PROGRAM: return 5'h19;
      OP_STAT_READ, OP_ID_READ: return 5'h12;
      OP_STAT_WRITE: return 5'h11;
      OP_CHIP_ERASE1, OP_CHIP_ERASE2, OP_WR_ENABLE: return 5'h10;
      OP_WR_DISABLE, OP_POWER_DOWN, OP_RESUME: return 5'h10;
      default: return 5'h00;
    endcase
  endfunction : attr

  task automatic run(logic [7:0] op, logic [23:0] a, int n);
    logic [4:0]  f;
    logic [23:0] am;
    int          m;
    logic [7:0]  d;
    f = attr(op);
    am = a & ADDR_MASK;
    m = (f[1] || f[0]) ? (n < 1 ? 1 : n) : 0;
    if (op == OP_PROGRAM && m > MAX_PROG) m = MAX_PROG;
    if (op == OP_ID_READ && m > MAX_ID) m = MAX_ID;
    if (op == OP_STAT_WRITE) m = 1;
    exp_err.push_back(!f[4]);
    if (f[4]) exp_tx.push_back({1'b0, op});
    if (f[3]) begin
      for (int i = 2; i >= 0; i--) begin
        exp_tx.push_back({1'b0, am[8*i+:8]});
      end
    end
    if (f[2]) exp_tx.push_back(9'h000);
    for (int k = 0; k < m; k++) begin
      d = 8'($random(seed));
      if (f[1]) begin
        exp_rd.push_back(8'(1 + 3 * f[3] + f[2] + k));
        exp_tx.push_back(9'h100);
      end else begin
        wq.push_back(d);
        exp_tx.push_back({1'b0, d});
      end
    end
    cmd = '{opcode: op, addr: a, count: 10'(n)};
    cmd_valid = 1'b1;
    for (int i = 0; i < 40000 && !cmd_ready; i++) @(negedge ref_clk);
    cmd_valid = 1'b0;
    repeat (2) @(negedge ref_clk);
  endtask : run

  // Stalls the write stream at random, never drops a held byte
  // Byte held through the edge that samples wr_ready high
  always @(negedge ref_clk) begin
    if (wr_seen) begin
      void'(wq.pop_front());
      wr_valid = 1'b0;
      wr_seen = 1'b0;
    end else if (wr_ready) begin
      wr_seen = 1'b1;
    end else if (!wr_valid && wq.size() > 0 && ($random(seed) & 3) != 0) begin
      wr_valid = 1'b1;
      wr_data = wq[0];
    end
  end

  always @(negedge ref_clk) begin
    if (rd_valid) cmp_byte("rd_data", exp_rd.pop_front(), rd_data);
    if (cmd_ready) begin
      cmp_bit("cmd_error", exp_err.pop_front(), cmd_error);
      while (i_dev.got.size() > 0) begin
        e = exp_tx.pop_front();
        if (!e[8]) begin
          cmp_byte("wire byte", e[7:0], i_dev.got.pop_front());
        end else begin
          void'(i_dev.got.pop_front());
        end
      end
    end
  end

  task automatic end_of_test();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : end_of_test

  initial begin
    repeat (90000) @(posedge ref_clk);
    fails++;
    end_of_test();
  end

  initial begin
    seed = 687;
    fails = 0;
    checks = 0;
    rst_n = 1'b0;
    cmd_valid = 1'b0;
    cmd = '0;
    wr_valid = 1'b0;
    wr_data = 8'h00;
    repeat (12) @(negedge ref_clk);
    rst_n = 1'b1;
    @(negedge ref_clk);
    foreach (op_list[i]) begin
      run(op_list[i], 24'($random(seed)), $random(seed) & 7);
    end
    run(OP_PROGRAM, 24'hffffff, 300);
    run(OP_PROGRAM, 24'hc00000, 0);
    run(OP_ID_READ, 24'h000000, 7);
    run(OP_READ_SLOW, 24'h3fffff, 0);
    run(8'h00, 24'h123456, 2);
    run(8'hff, 24'h000000, 0);
    cmp_bit("wire bytes left", 1'b1, exp_tx.size() == 0);
    cmp_bit("read bytes left", 1'b1, exp_rd.size() == 0);
    end_of_test();
  end
endmodule : flash_host_tb_top
